// File: hdl/rscs_map.svh
`ifndef RSCS_MAP_SVH
`define RSCS_MAP_SVH
// reset cause bit positions
`define RSCS_CAUSE_EXT 0
`define RSCS_CAUSE_POR 1
`define RSCS_CAUSE_BOR 2
`define RSCS_CAUSE_WDT 3
`define RSCS_CAUSE_SW 4
`define RSCS_CAUSE_W 5
// reset values
`define RSCS_CAUSE_RST 5'h02
`define RSCS_REGULATOR_VOLTAGE_ADJUST_RST 6'h00
`define RSCS_OSC_RST 3'h1
`define RSCS_SKIP_RST 1'b1
// oscillator source encodings
`define RSCS_OSC_MAIN 3'h0
`define RSCS_OSC_INT 3'h1
`define RSCS_OSC_QTR 3'h2
`define RSCS_OSC_LF 3'h3
`define RSCS_OSC_RTC 3'h7
// timing: internal reset pulse length
`define RSCS_RST_PULSE_NS 200
`define RSCS_CLK_NS 20
`define RSCS_RST_CYC ((`RSCS_RST_PULSE_NS + `RSCS_CLK_NS - 1) / `RSCS_CLK_NS)
`endif

// File: hdl/rscs_pkg.sv
package rscs_pkg;
	typedef enum logic [2:0] {
		RSCS_BOOT_IDLE = 3'b000,
		RSCS_BOOT_SP = 3'b001,
		RSCS_BOOT_PC = 3'b011,
		RSCS_BOOT_INSN = 3'b010,
		RSCS_BOOT_RUN = 3'b110
	} rscs_boot_e;
	typedef enum logic [2:0] {
		RSCS_CLK_PLL = 3'h0,
		RSCS_CLK_MAIN = 3'h1,
		RSCS_CLK_INT = 3'h2,
		RSCS_CLK_QTR = 3'h3,
		RSCS_CLK_LF = 3'h4,
		RSCS_CLK_RTC = 3'h5
	} rscs_clk_e;
endpackage

// File: hdl/rscs_soft_rst.sv
`timescale 1ns/100ps
// one peripheral soft-reset lane: set-then-clear fires a reset pulse
module rscs_soft_rst #(
	parameter int DOMAINS = 2
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic sys_rst_in,
	input wire logic ctrl_bit_in,
	output logic [DOMAINS-1:0] periph_rst_out
);
	logic ctrl_reg;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_bit_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			periph_rst_out <= '1;
		end else if (sys_rst_in || (ctrl_reg && !ctrl_bit_in)) begin
			periph_rst_out <= '1;
		end else begin
			periph_rst_out <= '0;
		end
	end
endmodule // rscs_soft_rst

// File: hdl/rscs_top.sv
`timescale 1ns/100ps
`include "rscs_map.svh"
module rscs_top #(
	parameter int PERIPHS = 16,
	parameter int DOMAINS = 2,
	parameter int WDT_W = 32,
	parameter int REGULATOR_VOLTAGE_ADJUST_W = 6
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic por_in,
	input wire logic ext_rst_in,
	input wire logic brownout_in,
	input wire logic brownout_reset_enable_in,
	input wire logic system_reset_request_in,
	input wire logic [PERIPHS-1:0] peripheral_soft_reset_regs_in,
	input wire logic wdt_enable_in,
	input wire logic wdt_reset_enable_in,
	input wire logic wdt_int_clear_in,
	input wire logic [WDT_W-1:0] watchdog_reload_value_in,
	input wire logic [REGULATOR_VOLTAGE_ADJUST_W-1:0] regulator_voltage_adjust_in,
	input wire logic pll_skip_select_in,
	input wire logic [2:0] osc_source_select_in,
	input wire logic use_ext_select_in,
	input wire logic [2:0] osc_source_select_ext_in,
	input wire logic boot_ack_in,
	output logic brownout_irq_out,
	output logic wdt_irq_out,
	output logic sys_rst_out,
	output logic [`RSCS_CAUSE_W-1:0] reset_cause_reg_out,
	output logic [PERIPHS*DOMAINS-1:0] periph_rst_out,
	output logic [REGULATOR_VOLTAGE_ADJUST_W-1:0] regulator_voltage_adjust_out,
	output rscs_pkg::rscs_clk_e clk_sel_out,
	output rscs_pkg::rscs_boot_e boot_state_out
);
	localparam int RST_CYC = `RSCS_RST_CYC;

	logic [WDT_W-1:0] wdt_cnt_reg;
	logic wdt_first_reg;
	logic wdt_fire;
	logic bor_rst;
	logic [7:0] pulse_cnt_reg;
	logic [3:0] rst_src;
	logic rst_next;

	// --------------------------------------------------
	// reset sources
	// --------------------------------------------------
	// gated by enable input low
	assign bor_rst = brownout_in && brownout_reset_enable_in;
	assign wdt_fire = wdt_enable_in && wdt_first_reg && !wdt_int_clear_in
		&& wdt_reset_enable_in && (wdt_cnt_reg == '0);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			brownout_irq_out <= 1'b0;
		end else begin
			brownout_irq_out <= brownout_in && !brownout_reset_enable_in;
		end
	end

	// --------------------------------------------------
	// watchdog
	// --------------------------------------------------
	// first timeout interrupts
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wdt_cnt_reg <= '1;
			wdt_first_reg <= 1'b0;
		end else if (sys_rst_out || !wdt_enable_in) begin
			wdt_cnt_reg <= watchdog_reload_value_in;
			wdt_first_reg <= 1'b0;
		end else if (wdt_cnt_reg == '0) begin
			wdt_cnt_reg <= watchdog_reload_value_in;
			wdt_first_reg <= 1'b1;
		end else begin
			wdt_cnt_reg <= wdt_cnt_reg - 1'b1;
			// set wins over clear
			if (wdt_int_clear_in) begin
				wdt_first_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wdt_irq_out <= 1'b0;
		end else begin
			wdt_irq_out <= wdt_first_reg || (wdt_enable_in
				&& wdt_cnt_reg == '0 && !sys_rst_out);
		end
	end

	// --------------------------------------------------
	// internal reset sequence
	// --------------------------------------------------
	// source bits, low to high: ext, bor, wdt, sw
	assign rst_src = {system_reset_request_in, wdt_fire, bor_rst,
		ext_rst_in};

	// held while brown-out or pin present
	// request pulse gives a fixed pulse
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pulse_cnt_reg <= 8'h00;
		end else if (rst_src[3] || rst_src[2]) begin
			pulse_cnt_reg <= 8'(RST_CYC);
		end else if (pulse_cnt_reg != 8'h00) begin
			pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
		end
	end

	assign rst_next = por_in || ext_rst_in || bor_rst
		|| (rst_src[3:2] != 2'b00) || (pulse_cnt_reg > 8'h01);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sys_rst_out <= 1'b1;
		end else begin
			sys_rst_out <= rst_next;
		end
	end

	// --------------------------------------------------
	// reset cause
	// --------------------------------------------------
	// sticky, power-on wipes others
	// set on assertion of each source
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reset_cause_reg_out <= `RSCS_CAUSE_RST;
		end else if (por_in) begin
			reset_cause_reg_out <= `RSCS_CAUSE_RST;
		end else begin
			if (rst_src[0]) reset_cause_reg_out[`RSCS_CAUSE_EXT] <= 1'b1;
			if (rst_src[1]) reset_cause_reg_out[`RSCS_CAUSE_BOR] <= 1'b1;
			if (rst_src[2]) reset_cause_reg_out[`RSCS_CAUSE_WDT] <= 1'b1;
			if (rst_src[3]) reset_cause_reg_out[`RSCS_CAUSE_SW] <= 1'b1;
		end
	end

	// --------------------------------------------------
	// boot fetch sequence
	// --------------------------------------------------
	// stack, pc, instruction, run
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			boot_state_out <= rscs_pkg::RSCS_BOOT_IDLE;
		end else if (sys_rst_out) begin
			boot_state_out <= rscs_pkg::RSCS_BOOT_IDLE;
		end else begin
			case (boot_state_out)
				rscs_pkg::RSCS_BOOT_IDLE: begin
					boot_state_out <= rscs_pkg::RSCS_BOOT_SP;
				end
				rscs_pkg::RSCS_BOOT_SP: begin
					if (boot_ack_in) boot_state_out <= rscs_pkg::RSCS_BOOT_PC;
				end
				rscs_pkg::RSCS_BOOT_PC: begin
					if (boot_ack_in) boot_state_out <= rscs_pkg::RSCS_BOOT_INSN;
				end
				rscs_pkg::RSCS_BOOT_INSN: begin
					if (boot_ack_in) boot_state_out <= rscs_pkg::RSCS_BOOT_RUN;
				end
				rscs_pkg::RSCS_BOOT_RUN: begin
					boot_state_out <= rscs_pkg::RSCS_BOOT_RUN;
				end
				default: begin
					boot_state_out <= rscs_pkg::RSCS_BOOT_IDLE;
				end
			endcase
		end
	end

	// --------------------------------------------------
	// peripheral soft resets
	// --------------------------------------------------
	// set then clear per peripheral
	for (genvar i = 0; i < PERIPHS; i++) begin : g_periph
		rscs_soft_rst #(
			.DOMAINS(DOMAINS)
		) u_lane (
			.clk_in(clk_in),
			.rst_n_in(rst_n_in),
			.sys_rst_in(sys_rst_out),
			.ctrl_bit_in(peripheral_soft_reset_regs_in[i]),
			.periph_rst_out(periph_rst_out[i*DOMAINS +: DOMAINS])
		);
	end

	// --------------------------------------------------
	// regulator and clock select
	// --------------------------------------------------
	// regulator step code passed through
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			regulator_voltage_adjust_out <= REGULATOR_VOLTAGE_ADJUST_W'(`RSCS_REGULATOR_VOLTAGE_ADJUST_RST);
		end else begin
			regulator_voltage_adjust_out <= regulator_voltage_adjust_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clk_sel_out <= rscs_pkg::RSCS_CLK_INT;
		end else if (por_in) begin
			clk_sel_out <= rscs_pkg::RSCS_CLK_INT;
		end else if (!pll_skip_select_in) begin
			clk_sel_out <= rscs_pkg::RSCS_CLK_PLL;
		end else if (use_ext_select_in
			&& osc_source_select_ext_in == `RSCS_OSC_RTC) begin
			clk_sel_out <= rscs_pkg::RSCS_CLK_RTC;
		end else begin
			case (osc_source_select_in)
				`RSCS_OSC_MAIN: clk_sel_out <= rscs_pkg::RSCS_CLK_MAIN;
				`RSCS_OSC_QTR: clk_sel_out <= rscs_pkg::RSCS_CLK_QTR;
				`RSCS_OSC_LF: clk_sel_out <= rscs_pkg::RSCS_CLK_LF;
				default: clk_sel_out <= rscs_pkg::RSCS_CLK_INT;
			endcase
		end
	end

	// --------------------------------------------------
	// checks
	// --------------------------------------------------
	// software request: a rising request, then the reset held
	sequence req_rise_s;
		$rose(system_reset_request_in);
	endsequence
	sequence rst_held_s;
		sys_rst_out [*3];
	endsequence

	bor_reset_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		bor_rst |=> sys_rst_out && reset_cause_reg_out[`RSCS_CAUSE_BOR])
		else $error("brown-out did not reset");
	bor_irq_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(brownout_in && !brownout_reset_enable_in) |=> brownout_irq_out)
		else $error("brown-out interrupt missing");
	bor_gate_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(brownout_in && !brownout_reset_enable_in && !por_in && !ext_rst_in
		&& !system_reset_request_in && !wdt_fire && pulse_cnt_reg <= 8'h01)
		|=> !sys_rst_out)
		else $error("brown-out reset while disabled");
	por_cause_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		por_in |=> reset_cause_reg_out == `RSCS_CAUSE_RST)
		else $error("power-on cause wrong");
	sw_pulse_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		req_rise_s |=> rst_held_s)
		else $error("request pulse too short");
	wdt_reset_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		wdt_fire |=> sys_rst_out && reset_cause_reg_out[`RSCS_CAUSE_WDT])
		else $error("watchdog reset missing");
	wdt_reload_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(wdt_enable_in && wdt_cnt_reg == '0 && !sys_rst_out)
		|=> wdt_cnt_reg == $past(watchdog_reload_value_in))
		else $error("watchdog reload wrong");
	clk_pll_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(!pll_skip_select_in && !por_in)
		|=> clk_sel_out == rscs_pkg::RSCS_CLK_PLL)
		else $error("pll select wrong");
	clk_por_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		por_in |=> clk_sel_out == rscs_pkg::RSCS_CLK_INT)
		else $error("clock not internal after power-on");
endmodule // rscs_top

// File: tb/rscs_top_bench.sv
`timescale 1ns/100ps
`include "rscs_map.svh"
module rscs_top_bench;
	logic clk_in = 1'b0, rst_n_in = 1'b0, por = 1'b0, ext = 1'b0;
	logic bo = 1'b0, bo_en = 1'b0, req = 1'b0, wen = 1'b0, wden = 1'b0;
	logic clr = 1'b0, skip = 1'b1, use_x = 1'b0, ack = 1'b0;
	logic [15:0] sr = 16'h0000;
	logic [31:0] wload = 32'h0000_0005;
	logic [5:0] regulator_voltage_adjust = 6'h00;
	logic [2:0] osel = 3'h1, xsel = 3'h0;
	logic bo_irq, wd_irq, srst;
	logic [4:0] cause;
	logic [31:0] prst, oth;
	logic [5:0] vout;
	rscs_pkg::rscs_clk_e csel;
	rscs_pkg::rscs_boot_e boot;
	int err_count = 0, checks = 0, exp_cause = 2, n, k, p, e;
	always #10 clk_in = ~clk_in;
	rscs_top i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .por_in(por),
		.ext_rst_in(ext), .brownout_in(bo), .brownout_reset_enable_in(bo_en),
		.system_reset_request_in(req), .peripheral_soft_reset_regs_in(sr),
		.wdt_enable_in(wen), .wdt_reset_enable_in(wden),
		.wdt_int_clear_in(clr), .watchdog_reload_value_in(wload),
		.regulator_voltage_adjust_in(regulator_voltage_adjust), .pll_skip_select_in(skip),
		.osc_source_select_in(osel), .use_ext_select_in(use_x),
		.osc_source_select_ext_in(xsel), .boot_ack_in(ack),
		.brownout_irq_out(bo_irq), .wdt_irq_out(wd_irq), .sys_rst_out(srst),
		.reset_cause_reg_out(cause), .periph_rst_out(prst),
		.regulator_voltage_adjust_out(vout), .clk_sel_out(csel),
		.boot_state_out(boot));
	task complete_run;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
		checks++;
		if (g !== ex) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, ex, g);
		end
	endtask
	task cyc(input int c);
		repeat (c) @(negedge clk_in);
	endtask
	// bounded wait; running out counts as a mismatch and ends the run
	task automatic wait_lvl(ref logic s, input logic lvl, input int b);
		int i;
		for (i = 0; i < b && s !== lvl; i++)
			@(negedge clk_in);
		if (s !== lvl) begin
			chk("wait level", lvl, s);
			complete_run();
		end
	endtask
	task hold_len;
		for (n = 0; n < 40 && srst === 1'b1; n++)
			cyc(1);
		chk("pulse length ok", 1, n >= `RSCS_RST_CYC && n <= `RSCS_RST_CYC + 1);
	endtask
	task boot_walk;
		rscs_pkg::rscs_boot_e sq [4];
		sq = '{rscs_pkg::RSCS_BOOT_SP, rscs_pkg::RSCS_BOOT_PC,
			rscs_pkg::RSCS_BOOT_INSN, rscs_pkg::RSCS_BOOT_RUN};
		cyc(1);
		chk("boot", sq[0], boot);
		for (k = 1; k < 4; k++) begin
			@(posedge clk_in) ack <= 1'b1;
			@(posedge clk_in) ack <= 1'b0;
			@(negedge clk_in);
			chk("boot", sq[k], boot);
		end
	endtask
	initial begin
		void'($urandom(91485));
		// --------------------------------
		// reset values and boot order
		// --------------------------------
		cyc(11);
		chk("srst", 1, srst);
		chk("cause", exp_cause, cause);
		chk("csel", rscs_pkg::RSCS_CLK_INT, csel);
		chk("prst", 32'hffff_ffff, prst);
		chk("irqs", 0, {bo_irq, wd_irq});
		@(posedge clk_in) rst_n_in <= 1'b1;
		wait_lvl(srst, 1'b0, 5);
		boot_walk();
		// oscillator taken as stable, reference in range
		for (n = 0; n < 24; n++) begin
			@(posedge clk_in);
			skip <= 1'($urandom % 2);
			osel <= 3'($urandom % 4);
			use_x <= 1'($urandom % 2);
			xsel <= ($urandom % 2) ? 3'h7 : 3'($urandom % 7);
			regulator_voltage_adjust <= 6'($urandom);
			cyc(2);
			e = !skip ? 0 : (use_x && xsel == 3'h7) ? 5 : osel + 1;
			chk("csel", e, csel);
			chk("vout", regulator_voltage_adjust, vout);
		end
		// --------------------------------
		// brown-out
		// --------------------------------
		@(posedge clk_in) bo <= 1'b1;
		cyc(3);
		chk("bo_irq", 1, bo_irq);
		chk("srst", 0, srst);
		@(posedge clk_in) bo <= 1'b0;
		bo_en <= 1'b1;
		cyc(2);
		@(posedge clk_in) bo <= 1'b1;
		wait_lvl(srst, 1'b1, 3);
		cyc(15);
		exp_cause |= 4;
		chk("srst held", 1, srst);
		chk("cause", exp_cause, cause);
		@(posedge clk_in) bo <= 1'b0;
		bo_en <= 1'b0;
		wait_lvl(srst, 1'b0, 3);
		boot_walk();
		// peripheral lanes: one pulse on both domains, other lanes quiet
		for (n = 0; n < 4; n++) begin
			p = $urandom % 16;
			@(posedge clk_in) sr[p] <= 1'b1;
			@(posedge clk_in) sr[p] <= 1'b0;
			e = 0;
			oth = 32'h0000_0000;
			for (k = 0; k < 5; k++) begin
				@(negedge clk_in);
				e += (prst[2*p+:2] === 2'b11);
				oth |= prst & ~(32'h0000_0003 << 2 * p);
			end
			chk("lane pulses", 1, e);
			chk("other lanes", 0, oth);
		end
		@(posedge clk_in) req <= 1'b1;
		@(posedge clk_in) req <= 1'b0;
		cyc(1);
		exp_cause |= 16;
		chk("srst", 1, srst);
		chk("cause", exp_cause, cause);
		hold_len();
		boot_walk();
		// --------------------------------
		// watchdog
		// --------------------------------
		@(posedge clk_in) wen <= 1'b1;
		wait_lvl(wd_irq, 1'b1, 60);
		@(posedge clk_in) wden <= 1'b1;
		wait_lvl(srst, 1'b1, 20);
		exp_cause |= 8;
		chk("cause", exp_cause, cause);
		hold_len();
		@(posedge clk_in) wen <= 1'b0;
		wden <= 1'b0;
		clr <= 1'b1;
		@(posedge clk_in) clr <= 1'b0;
		cyc(2);
		chk("wd_irq", 0, wd_irq);
		// reset output disabled: timeouts must not reset
		@(posedge clk_in) wen <= 1'b1;
		wait_lvl(wd_irq, 1'b1, 60);
		e = 0;
		for (k = 0; k < 30; k++) begin
			cyc(1);
			e += (srst !== 1'b0);
		end
		chk("wdt no reset", 0, e);
		@(posedge clk_in) wen <= 1'b0;
		@(posedge clk_in) ext <= 1'b1;
		wait_lvl(srst, 1'b1, 3);
		@(posedge clk_in) ext <= 1'b0;
		wait_lvl(srst, 1'b0, 4);
		exp_cause |= 1;
		chk("sticky cause", exp_cause, cause);
		// pll first, so that power-on really has to move the select
		@(posedge clk_in) skip <= 1'b0;
		cyc(2);
		chk("csel pll", rscs_pkg::RSCS_CLK_PLL, csel);
		@(posedge clk_in) por <= 1'b1;
		cyc(3);
		chk("csel por", rscs_pkg::RSCS_CLK_INT, csel);
		@(posedge clk_in) por <= 1'b0;
		wait_lvl(srst, 1'b0, 5);
		chk("cause por", 2, cause);
		complete_run();
	end
endmodule // rscs_top_bench
